// File: isr_params.svh
// constants of the status reporting block: bit positions, resets, codes
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

// status byte bit positions
`define ISR_STB_EVQ 2
`define ISR_STB_QUES 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OPER 7

// standard event latch bit positions
`define ISR_ESR_OPC 0
`define ISR_ESR_RQC 1
`define ISR_ESR_QYE 2
`define ISR_ESR_DDE 3
`define ISR_ESR_EXE 4
`define ISR_ESR_CME 5
`define ISR_ESR_URQ 6
`define ISR_ESR_PON 7

// reset values and implemented-bit mask
`define ISR_ESR_RST 8'h80
`define ISR_ESR_IMPL 8'hbd
`define ISR_SRE_RST 8'h00
`define ISR_ESE_RST 8'h00

// error queue
`define ISR_EQ_DEPTH 10
`define ISR_CODE_NONE 16'sh0000
`define ISR_CODE_OVF 16'shfea2

// error class ranges, signed 16-bit
`define ISR_CME_HI 16'shff9c
`define ISR_CME_LO 16'shff39
`define ISR_EXE_HI 16'shff38
`define ISR_EXE_LO 16'shfed5
`define ISR_DDE_HI 16'shfed4
`define ISR_DDE_LO 16'shfe71
`define ISR_QYE_HI 16'shfe70
`define ISR_QYE_LO 16'shfe0d

`endif

// File: isr_pkg.sv
// types shared by the status reporting block
package isr_pkg;
	typedef enum logic [3:0] {
		ISR_CMD_NONE = 4'h0,
		ISR_CMD_STB_Q = 4'h1,
		ISR_CMD_SRE_W = 4'h2,
		ISR_CMD_SRE_Q = 4'h3,
		ISR_CMD_ESE_W = 4'h4,
		ISR_CMD_ESE_Q = 4'h5,
		ISR_CMD_ESR_Q = 4'h6,
		ISR_CMD_OPC = 4'h7,
		ISR_CMD_ERR_Q = 4'h8
	} isr_cmd_e;
	typedef logic signed [15:0] isr_code_t;
endpackage : isr_pkg

// File: isr_eq_if.sv
// carrier between the status core and its error queue
`timescale 1ns/1ps
interface isr_eq_if;
	import isr_pkg::*;
	logic push;
	isr_code_t push_code;
	logic pop;
	isr_code_t head;
	logic nonempty;
	logic ovf;
	modport ctl (output push, output push_code, output pop,
		input head, input nonempty, input ovf);
	modport que (input push, input push_code, input pop,
		output head, output nonempty, output ovf);
endinterface : isr_eq_if

// File: isr_err_queue.sv
// cyclic error code queue with overflow marking
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_err_queue import isr_pkg::*; #(
	parameter int DEPTH = `ISR_EQ_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	isr_eq_if.que q
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	isr_code_t mem_q [DEPTH];
	logic [AW-1:0] rd_q;
	logic [AW-1:0] wr_q;
	logic [AW:0] cnt_q;
	logic ovf_q;
	logic full;
	logic pop_ok;
	logic push_ok;

	function automatic logic [AW-1:0] eq_inc(input logic [AW-1:0] p);
		eq_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : eq_inc

	function automatic logic [AW-1:0] eq_dec(input logic [AW-1:0] p);
		eq_dec = (p == '0) ? AW'(DEPTH - 1) : AW'(p - 1'b1);
	endfunction : eq_dec

	assign full = (cnt_q == FULL_CNT);
	assign pop_ok = q.pop && (cnt_q != '0);
	// a pop in the same cycle frees room for the push
	assign push_ok = q.push && (!full || pop_ok);

	always_ff @(posedge clk_sys) begin
		if (push_ok) begin
			mem_q[wr_q] <= q.push_code; // [RULE18]
		end else if (q.push) begin
			// newest slot gives way to the overflow marker
			mem_q[eq_dec(wr_q)] <= `ISR_CODE_OVF; // [RULE24]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push_ok)
				wr_q <= eq_inc(wr_q); // [RULE18]
			if (pop_ok)
				rd_q <= eq_inc(rd_q); // [RULE19]
			if (push_ok && !pop_ok)
				cnt_q <= cnt_q + 1'b1;
			else if (pop_ok && !push_ok)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			ovf_q <= 1'b0;
		else
			ovf_q <= q.push && !push_ok; // [RULE24]
	end

	// empty queue answers with the no-error code
	assign q.head = (cnt_q != '0) ? mem_q[rd_q] : `ISR_CODE_NONE; // [RULE24]
	assign q.nonempty = (cnt_q != '0);
	assign q.ovf = ovf_q;

	property p_cnt_bound;
		@(posedge clk_sys) disable iff (rst)
		cnt_q <= FULL_CNT;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) // [RULE18]
		else $error("error queue count above depth");

	property p_ovf_mark;
		@(posedge clk_sys) disable iff (rst)
		(q.push && full && !q.pop) |=> ovf_q && (cnt_q == FULL_CNT)
			&& (mem_q[eq_dec(wr_q)] == `ISR_CODE_OVF);
	endproperty
	a_ovf_mark: assert property (p_ovf_mark) // [RULE24]
		else $error("overflow not marked in newest slot");

	property p_pop_adv;
		@(posedge clk_sys) disable iff (rst)
		(q.pop && cnt_q != '0 && !q.push) |=> cnt_q == $past(cnt_q) - 1'b1;
	endproperty
	a_pop_adv: assert property (p_pop_adv) // [RULE19]
		else $error("read did not advance the error queue");
endmodule : isr_err_queue

// File: isr_status.sv
// status byte, standard event latch and error queue summary core
//
// Notes on behaviour
// [RULE1] EVQ set while error queue is non-empty
// [RULE2] MAV follows response waiting in output queue
// [RULE3] ESB set when enabled standard event latched
// [RULE4] RQS set, service requested on enabled summary
// [RULE5] bits 7, 1, 0 of status byte stay zero
// [RULE6] serial poll reads status byte, clears RQS
// [RULE7] status byte query returns the status byte
// [RULE8] service mask is 8 bits, write and read
// [RULE9] OPC command sets event bit 0
// [RULE10] event bits 1 and 6 never set
// [RULE11] query errors set event bit 2
// [RULE12] device errors set event bit 3
// [RULE13] execution errors set event bit 4
// [RULE14] syntax errors set event bit 5
// [RULE15] power-up sets event bit 7
// [RULE16] event latch query returns the latch
// [RULE17] event mask gates latch onto ESB, read/write
// [RULE18] error codes kept in ten-entry cyclic buffer
// [RULE19] error query returns oldest then removes it
// [RULE20] errors reported as signed codes
// [RULE21] codes -100 to -199 set CME
// [RULE22] execution error codes set EXE
// [RULE23] device-specific codes set DDE
// [RULE24] overflow records -350, zero means none pending
// [RULE25] event latch cleared after its query
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_status import isr_pkg::*; #(
	parameter int EQ_DEPTH = `ISR_EQ_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire isr_cmd_e cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic mav,
	input wire logic err_valid,
	input wire isr_code_t err_code,
	input wire logic qye_evt,
	input wire logic spoll,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic spoll_valid,
	output logic [7:0] spoll_byte,
	output logic srq,
	output logic [7:0] status_byte
);
	isr_eq_if eq ();

	logic [7:0] esr_q;
	logic [7:0] sre_q;
	logic [7:0] ese_q;
	logic rqs_q;
	logic svc_prev_q;
	logic rsp_valid_q;
	logic [15:0] rsp_data_q;
	logic spoll_valid_q;
	logic [7:0] spoll_byte_q;
	logic [7:0] status_byte_q;

	logic [7:0] ev_set;
	logic [7:0] summary;
	logic [7:0] stb_now;
	logic esb;
	logic svc;
	logic svc_rise;
	logic is_query;
	logic op_esr_q;

	// event bit raised by one queued error code
	function automatic logic [7:0] isr_classify(input isr_code_t c);
		logic [7:0] m;
		m = 8'h00;
		if (c > `ISR_CODE_NONE)
			m[`ISR_ESR_DDE] = 1'b1; // [RULE23]
		else if (c <= `ISR_CME_HI && c >= `ISR_CME_LO)
			m[`ISR_ESR_CME] = 1'b1; // [RULE21] [RULE14]
		else if (c <= `ISR_EXE_HI && c >= `ISR_EXE_LO)
			m[`ISR_ESR_EXE] = 1'b1; // [RULE22] [RULE13]
		else if (c <= `ISR_DDE_HI && c >= `ISR_DDE_LO)
			m[`ISR_ESR_DDE] = 1'b1; // [RULE23] [RULE12]
		else if (c <= `ISR_QYE_HI && c >= `ISR_QYE_LO)
			m[`ISR_ESR_QYE] = 1'b1; // [RULE11]
		isr_classify = m;
	endfunction : isr_classify

	isr_err_queue #(
		.DEPTH(EQ_DEPTH)
	) u_queue (
		.clk_sys(clk_sys),
		.rst(rst),
		.q(eq)
	);

	assign eq.push = err_valid; // [RULE18]
	assign eq.push_code = err_code;
	assign eq.pop = cmd_valid && (cmd_op == ISR_CMD_ERR_Q); // [RULE19]

	assign op_esr_q = cmd_valid && (cmd_op == ISR_CMD_ESR_Q);

	// all events that land this cycle, by class
	always_comb begin
		ev_set = 8'h00;
		if (err_valid)
			ev_set = ev_set | isr_classify(err_code);
		if (eq.ovf)
			ev_set = ev_set | isr_classify(`ISR_CODE_OVF); // [RULE24]
		if (qye_evt)
			ev_set[`ISR_ESR_QYE] = 1'b1; // [RULE11]
		if (cmd_valid && cmd_op == ISR_CMD_OPC)
			ev_set[`ISR_ESR_OPC] = 1'b1; // [RULE9]
	end

	// query clears the latch, but a same-cycle event survives it
	always_ff @(posedge clk_sys) begin
		if (rst)
			esr_q <= `ISR_ESR_RST; // [RULE15]
		else if (op_esr_q)
			esr_q <= ev_set & `ISR_ESR_IMPL; // [RULE25]
		else
			esr_q <= (esr_q | ev_set) & `ISR_ESR_IMPL; // [RULE10]
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			sre_q <= `ISR_SRE_RST;
		else if (cmd_valid && cmd_op == ISR_CMD_SRE_W)
			sre_q <= cmd_data; // [RULE8]
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			ese_q <= `ISR_ESE_RST;
		else if (cmd_valid && cmd_op == ISR_CMD_ESE_W)
			ese_q <= cmd_data; // [RULE17]
	end

	assign esb = |(esr_q & ese_q); // [RULE3]

	// questionable and operation summaries have no sources here
	always_comb begin
		summary = 8'h00;
		summary[`ISR_STB_EVQ] = eq.nonempty; // [RULE1]
		summary[`ISR_STB_MAV] = mav; // [RULE2]
		summary[`ISR_STB_ESB] = esb; // [RULE3]
	end

	// the rqs position of the mask is ignored, it cannot feed itself
	assign svc = |(summary & sre_q); // [RULE4]
	assign svc_rise = svc && !svc_prev_q;

	always_comb begin
		stb_now = summary;
		stb_now[`ISR_STB_RQS] = rqs_q; // [RULE5]
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			svc_prev_q <= 1'b0;
		else
			svc_prev_q <= svc;
	end

	// only a fresh reason requests service, so a poll is not undone
	// by a summary that stays high; a new reason wins over the poll
	always_ff @(posedge clk_sys) begin
		if (rst)
			rqs_q <= 1'b0;
		else if (svc_rise)
			rqs_q <= 1'b1; // [RULE4]
		else if (spoll)
			rqs_q <= 1'b0; // [RULE6]
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			spoll_valid_q <= 1'b0;
			spoll_byte_q <= 8'h00;
		end else begin
			spoll_valid_q <= spoll;
			if (spoll)
				spoll_byte_q <= stb_now; // [RULE6]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			status_byte_q <= 8'h00;
		else
			status_byte_q <= stb_now;
	end

	always_comb begin
		is_query = 1'b0;
		if (cmd_valid) begin
			unique case (cmd_op)
			ISR_CMD_STB_Q, ISR_CMD_SRE_Q, ISR_CMD_ESE_Q,
			ISR_CMD_ESR_Q, ISR_CMD_ERR_Q: is_query = 1'b1;
			default: is_query = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			rsp_valid_q <= 1'b0;
		else
			rsp_valid_q <= is_query;
	end

	// byte answers sit in the low half; error codes use all 16 bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_data_q <= 16'h0000;
		end else if (is_query) begin
			unique case (cmd_op)
			ISR_CMD_STB_Q: rsp_data_q <= {8'h00, stb_now}; // [RULE7]
			ISR_CMD_SRE_Q: rsp_data_q <= {8'h00, sre_q}; // [RULE8]
			ISR_CMD_ESE_Q: rsp_data_q <= {8'h00, ese_q}; // [RULE17]
			ISR_CMD_ESR_Q: rsp_data_q <= {8'h00, esr_q}; // [RULE16]
			default: rsp_data_q <= eq.head; // [RULE20]
			endcase
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign spoll_valid = spoll_valid_q;
	assign spoll_byte = spoll_byte_q;
	assign srq = rqs_q;
	assign status_byte = status_byte_q;

	property p_evq;
		@(posedge clk_sys) disable iff (rst)
		eq.nonempty |=> status_byte_q[`ISR_STB_EVQ];
	endproperty
	a_evq: assert property (p_evq) // [RULE1]
		else $error("EVQ low with errors queued");

	property p_mav;
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> status_byte_q[`ISR_STB_MAV] == $past(mav);
	endproperty
	a_mav: assert property (p_mav) // [RULE2]
		else $error("MAV does not follow output queue");

	property p_esb;
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> status_byte_q[`ISR_STB_ESB] == $past(|(esr_q & ese_q));
	endproperty
	a_esb: assert property (p_esb) // [RULE3]
		else $error("ESB disagrees with enabled events");

	property p_rqs_set;
		@(posedge clk_sys) disable iff (rst)
		svc_rise |=> rqs_q ##1 status_byte_q[`ISR_STB_RQS];
	endproperty
	a_rqs_set: assert property (p_rqs_set) // [RULE4]
		else $error("enabled summary did not request service");

	property p_unused_stb;
		@(posedge clk_sys) disable iff (rst)
		status_byte_q[`ISR_STB_OPER] == 1'b0
			&& status_byte_q[1:0] == 2'b00;
	endproperty
	a_unused_stb: assert property (p_unused_stb) // [RULE5]
		else $error("unused status byte bit set");

	property p_poll;
		@(posedge clk_sys) disable iff (rst)
		(spoll && !svc_rise) |=> !rqs_q && spoll_valid_q
			&& spoll_byte_q == $past(stb_now);
	endproperty
	a_poll: assert property (p_poll) // [RULE6]
		else $error("serial poll answer or RQS clear wrong");

	property p_stb_query;
		@(posedge clk_sys) disable iff (rst)
		(cmd_valid && cmd_op == ISR_CMD_STB_Q) |=> rsp_valid_q
			&& rsp_data_q == {8'h00, $past(stb_now)};
	endproperty
	a_stb_query: assert property (p_stb_query) // [RULE7]
		else $error("status byte query answer wrong");

	property p_opc;
		@(posedge clk_sys) disable iff (rst)
		(cmd_valid && cmd_op == ISR_CMD_OPC) |=> esr_q[`ISR_ESR_OPC];
	endproperty
	a_opc: assert property (p_opc) // [RULE9]
		else $error("OPC command did not latch");

	property p_unimpl;
		@(posedge clk_sys) disable iff (rst)
		!esr_q[`ISR_ESR_RQC] && !esr_q[`ISR_ESR_URQ];
	endproperty
	a_unimpl: assert property (p_unimpl) // [RULE10]
		else $error("unimplemented event bit set");

	property p_cme_code;
		@(posedge clk_sys) disable iff (rst)
		(err_valid && err_code <= `ISR_CME_HI && err_code >= `ISR_CME_LO)
			|=> esr_q[`ISR_ESR_CME];
	endproperty
	a_cme_code: assert property (p_cme_code) // [RULE21]
		else $error("command error code did not set CME");

	property p_esr_clear;
		@(posedge clk_sys) disable iff (rst)
		(op_esr_q && ev_set == 8'h00) |=> esr_q == 8'h00
			&& rsp_data_q == {8'h00, $past(esr_q)};
	endproperty
	a_esr_clear: assert property (p_esr_clear) // [RULE25]
		else $error("event latch query did not read and clear");

	property p_err_read;
		@(posedge clk_sys) disable iff (rst)
		(cmd_valid && cmd_op == ISR_CMD_ERR_Q) |=> rsp_valid_q
			&& rsp_data_q == $past(eq.head);
	endproperty
	a_err_read: assert property (p_err_read) // [RULE19]
		else $error("error query did not return oldest code");

	property p_sre_query;
		@(posedge clk_sys) disable iff (rst)
		(cmd_valid && cmd_op == ISR_CMD_SRE_Q) |=> rsp_valid_q
			&& rsp_data_q == {8'h00, $past(sre_q)};
	endproperty
	a_sre_query: assert property (p_sre_query) // [RULE8]
		else $error("service mask query answer wrong");

	property p_qye;
		@(posedge clk_sys) disable iff (rst)
		qye_evt |=> esr_q[`ISR_ESR_QYE];
	endproperty
	a_qye: assert property (p_qye) // [RULE11]
		else $error("query error did not latch");

	property p_exe_code;
		@(posedge clk_sys) disable iff (rst)
		(err_valid && err_code <= `ISR_EXE_HI && err_code >= `ISR_EXE_LO)
			|=> esr_q[`ISR_ESR_EXE];
	endproperty
	a_exe_code: assert property (p_exe_code) // [RULE22]
		else $error("execution error code did not set EXE");

	property p_pon;
		@(posedge clk_sys)
		($past(rst) && !rst) |-> esr_q[`ISR_ESR_PON];
	endproperty
	a_pon: assert property (p_pon) // [RULE15]
		else $error("power-on event missing after reset");
endmodule : isr_status

// File: isr_ctl_model.sv
// bus controller model: issues common commands and serial polls
`timescale 1ns/1ps
module isr_ctl_model import isr_pkg::*; (
	input wire logic clk_sys,
	output logic cmd_valid,
	output isr_cmd_e cmd_op,
	output logic [7:0] cmd_data,
	output logic spoll,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic spoll_valid,
	input wire logic [7:0] spoll_byte
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = ISR_CMD_NONE;
		cmd_data = 8'h00;
		spoll = 1'b0;
	end

	// answer stands for one cycle only, so it is taken right after the edge
	task automatic send(input isr_cmd_e op, input logic [7:0] d,
		output logic v, output logic [15:0] r);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_op <= ISR_CMD_NONE;
		// released data must not keep looking valid
		cmd_data <= ~d;
		#1;
		v = rsp_valid;
		r = rsp_data;
	endtask : send

	task automatic poll(output logic v, output logic [7:0] b);
		@(posedge clk_sys);
		spoll <= 1'b1;
		@(posedge clk_sys);
		spoll <= 1'b0;
		#1;
		v = spoll_valid;
		b = spoll_byte;
	endtask : poll
endmodule : isr_ctl_model

// File: ieee488_status_reporting_test.sv
// self-checking bench of the status reporting core
`timescale 1ns/1ps
`include "isr_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
bad_count++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
end end
module ieee488_status_reporting_test import isr_pkg::*; ();
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic mav = 1'b0;
	logic err_valid = 1'b0;
	logic qye_evt = 1'b0;
	isr_code_t err_code = 16'sh0000;
	logic cmd_valid, spoll, rsp_valid, spoll_valid, srq, v;
	isr_cmd_e cmd_op;
	logic [7:0] cmd_data, spoll_byte, status_byte, b;
	logic [15:0] rsp_data, r, exp_b;
	logic [31:0] seed = 32'hb4e0;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	isr_code_t codes [0:10];

	always #2.5 clk_sys = ~clk_sys;

	isr_status uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .mav(mav),
		.err_valid(err_valid), .err_code(err_code), .qye_evt(qye_evt),
		.spoll(spoll), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .srq(srq),
		.status_byte(status_byte));

	isr_ctl_model ctl (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .spoll(spoll),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.spoll_valid(spoll_valid), .spoll_byte(spoll_byte));

	function automatic void step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction : step

	// event bit that queuing a code should latch
	function automatic logic [15:0] exp_evt(input isr_code_t c);
		int k;
		k = c;
		if (k <= -100 && k >= -199) return 16'h0020;
		if (k <= -200 && k >= -299) return 16'h0010;
		if ((k <= -300 && k >= -399) || k > 0) return 16'h0008;
		if (k <= -400 && k >= -499) return 16'h0004;
		return 16'h0000;
	endfunction : exp_evt

	task automatic conclude();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic q(input isr_cmd_e op, input logic [15:0] e,
		input string nm);
		ctl.send(op, 8'h00, v, r);
		`CHK(nm, 1'b1, v)
		`CHK(nm, e, r)
	endtask : q

	task automatic w(input isr_cmd_e op, input logic [7:0] d);
		ctl.send(op, d, v, r);
		`CHK("write answer", 1'b0, v)
	endtask : w

	task automatic push(input isr_code_t c);
		@(posedge clk_sys);
		err_valid <= 1'b1;
		err_code <= c;
		@(posedge clk_sys);
		err_valid <= 1'b0;
		err_code <= ~c;
	endtask : push

	initial begin
		codes[0] = -16'sd102;
		codes[1] = -16'sd222;
		codes[2] = -16'sd315;
		codes[3] = 16'sd7;
		codes[4] = -16'sd410;
		codes[5] = -16'sd500;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		q(ISR_CMD_ESR_Q, 16'h0080, "esr pon");
		q(ISR_CMD_ESR_Q, 16'h0000, "esr clr");
		for (int i = 0; i < 4; i++) begin
			step();
			w(ISR_CMD_SRE_W, seed[7:0]);
			q(ISR_CMD_SRE_Q, {8'h00, seed[7:0]}, "sre");
			w(ISR_CMD_ESE_W, seed[15:8]);
			q(ISR_CMD_ESE_Q, {8'h00, seed[15:8]}, "ese");
		end
		w(ISR_CMD_SRE_W, 8'h00);
		w(ISR_CMD_ESE_W, 8'h00);
		w(ISR_CMD_OPC, 8'h00);
		q(ISR_CMD_ESR_Q, 16'h0001, "esr opc");
		@(posedge clk_sys);
		qye_evt <= 1'b1;
		@(posedge clk_sys);
		qye_evt <= 1'b0;
		q(ISR_CMD_ESR_Q, 16'h0004, "esr qye");
		@(posedge clk_sys);
		mav <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("stb mav", 8'h10, status_byte)
		q(ISR_CMD_STB_Q, 16'h0010, "stb query");
		@(posedge clk_sys);
		mav <= 1'b0;
		// every error class, then the queue hands them back in order
		for (int i = 0; i < 6; i++) begin
			push(codes[i]);
			exp_b = exp_evt(codes[i]);
			q(ISR_CMD_ESR_Q, exp_b, "esr class");
		end
		#1;
		`CHK("stb evq", 1'b1, status_byte[2])
		for (int i = 0; i < 6; i++)
			q(ISR_CMD_ERR_Q, codes[i], "err order");
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("stb empty", 8'h00, status_byte)
		q(ISR_CMD_ERR_Q, 16'h0000, "err none");
		w(ISR_CMD_ESE_W, 8'h20);
		w(ISR_CMD_SRE_W, 8'h20);
		push(-16'sd102);
		for (int n = 0; n < 8 && srq !== 1'b1; n++)
			@(posedge clk_sys);
		#1;
		`CHK("srq", 1'b1, srq)
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("stb esb", 8'h64, status_byte)
		ctl.poll(v, b);
		`CHK("poll valid", 1'b1, v)
		`CHK("poll byte", 8'h64, b)
		@(posedge clk_sys);
		#1;
		`CHK("srq cleared", 1'b0, srq)
		q(ISR_CMD_ERR_Q, 16'hff9a, "err cme");
		q(ISR_CMD_ESR_Q, 16'h0020, "esr cme");
		w(ISR_CMD_SRE_W, 8'h00);
		w(ISR_CMD_ESE_W, 8'h00);
		// eleven errors unread: the newest slot turns into overflow
		for (int i = 0; i < 11; i++) begin
			step();
			codes[i] = -16'sd100 - {10'h000, seed[5:0]};
			push(codes[i]);
		end
		@(posedge clk_sys);
		q(ISR_CMD_ESR_Q, 16'h0028, "esr overflow");
		for (int i = 0; i < 9; i++)
			q(ISR_CMD_ERR_Q, codes[i], "err kept");
		q(ISR_CMD_ERR_Q, `ISR_CODE_OVF, "err ovf");
		q(ISR_CMD_ERR_Q, 16'h0000, "err drained");
		conclude();
	end
endmodule : ieee488_status_reporting_test
